// ---- design/tdp_consts.svh ----
`ifndef TDP_CONSTS_SVH
`define TDP_CONSTS_SVH

`define TDP_FSEL_HI 13
`define TDP_FSEL_LO 11
`define TDP_PIN_EN_BIT 10
`define TDP_STORE_BIT 4
`define TDP_CODE_HI 11
`define TDP_CODE_LO 2
`define TDP_GAIN_HI 1
`define TDP_GAIN_LO 0
`define TDP_FUNC_TRIGGER 3'h1
`define TDP_FUNC_TWO_CODE 3'h2
`define TDP_FUNC_POWER 3'h4
`define TDP_RST_SETUP2 16'h0000
`define TDP_RST_COMMAND 16'h0000
`define TDP_RST_GENERAL 16'h0000
`define TDP_RST_CODE 16'h0000
`define TDP_STORE_CYCLES 8'h10

`endif

// ---- design/tdp_control.sv ----
// Contract
// - a function-select field picks what the input pin drives
// - two-code function: pin level picks upper or lower threshold code
// - two-code function starts on the lower code after start-up
// - power function: pin high powers up, low powers down, main code used
// - host writes one to store field, device saves settings
// - after reset, stored settings reload every applicable register
// - internal reference gain has four settings: 1.5, 2, 3, 4
// - function select sits at bits 13:11 of setup reg, 0b010 two-code
// - pin acted on only when command bit 10 is one
// - store strobe is command bit 4
// - threshold registers keep 10-bit code in bits 11:2
`timescale 1ns/1ps
`include "tdp_consts.svh"
module tdp_control #(
	parameter int CODE_W = 10
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic general_input_pin,
	input wire logic [15:0] wr_data,
	input wire logic wr_setup2,
	input wire logic wr_command,
	input wire logic wr_general,
	input wire logic wr_main,
	input wire logic wr_upper,
	input wire logic wr_lower,
	output logic [CODE_W-1:0] out_code,
	output tdp_pkg::tdp_sel_t out_select,
	output logic out_powered,
	output logic out_pulldown,
	output tdp_pkg::tdp_gain_t ref_gain,
	output logic trigger_pulse,
	output logic store_busy,
	output logic store_valid
);
	import tdp_pkg::*;

	typedef struct packed {
		logic [15:0] setup2;
		logic [15:0] general;
		logic [CODE_W-1:0] main_code;
		logic [CODE_W-1:0] upper_code;
		logic [CODE_W-1:0] lower_code;
		logic pin_enable;
	} tdp_set_t;

	tdp_pin_if pin();
	tdp_set_t live;
	tdp_set_t persistent_store;
	logic loading;
	logic [7:0] store_count;
	logic [2:0] func;
	logic store_go;
	logic two_code_on;
	logic power_on;
	logic trigger_on;
	// survives reset like the store itself; clear at start only because the store is blank
	logic programmed = 1'b0;
	typedef enum logic {TDP_STORE_IDLE, TDP_STORE_PROG} tdp_store_t;
	tdp_store_t store_state;

	function automatic logic [CODE_W-1:0] code_field(input logic [15:0] word);
		code_field = word[`TDP_CODE_HI:`TDP_CODE_LO];
	endfunction

	// a pin function acts only while the pin is enabled
	function automatic logic mode_on(input logic en, input logic [2:0] sel, input logic [2:0] want);
		mode_on = en && (sel == want);
	endfunction

	tdp_pin_sync u_sync (
		.clock(clock),
		.resetn(resetn),
		.general_input_pin(general_input_pin),
		.pin(pin)
	);

	assign func = live.setup2[`TDP_FSEL_HI:`TDP_FSEL_LO];

	// one strobe test shared by the store copy, the flag and the sequencer
	assign store_go = resetn && !loading && !store_busy
		&& wr_command && wr_data[`TDP_STORE_BIT];

	assign two_code_on = mode_on(live.pin_enable, func, `TDP_FUNC_TWO_CODE);
	assign power_on = mode_on(live.pin_enable, func, `TDP_FUNC_POWER);
	assign trigger_on = mode_on(live.pin_enable, func, `TDP_FUNC_TRIGGER);

	// live registers; a reset leaves them at defaults for one cycle, then reload
	always_ff @(posedge clock) begin
		if (!resetn) begin
			live.setup2 <= `TDP_RST_SETUP2;
			live.general <= `TDP_RST_GENERAL;
			live.main_code <= CODE_W'(`TDP_RST_CODE);
			live.upper_code <= CODE_W'(`TDP_RST_CODE);
			live.lower_code <= CODE_W'(`TDP_RST_CODE);
			live.pin_enable <= 1'b0;
		end else if (loading) begin
			if (store_valid)
				live <= persistent_store;
		end else begin
			if (wr_setup2)
				live.setup2 <= wr_data;
			if (wr_general)
				live.general <= wr_data;
			if (wr_main)
				live.main_code <= code_field(wr_data);
			if (wr_upper)
				live.upper_code <= code_field(wr_data);
			if (wr_lower)
				live.lower_code <= code_field(wr_data);
			if (wr_command)
				live.pin_enable <= wr_data[`TDP_PIN_EN_BIT];
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn)
			loading <= 1'b1;
		else
			loading <= 1'b0;
	end

	// store array is not reset: it models contents that survive a power cycle
	always_ff @(posedge clock) begin
		if (store_go)
			persistent_store <= live;
	end

	// programmed flag must survive reset too, so only the store sets it
	always_ff @(posedge clock) begin
		if (store_go)
			programmed <= 1'b1;
	end

	// port copy of the flag; it already reads set in the cycle after the strobe
	always_ff @(posedge clock) begin
		store_valid <= programmed || store_go;
	end

	// busy time models the program cycle; a strobe meanwhile is dropped, not queued
	always_ff @(posedge clock) begin
		if (!resetn) begin
			store_state <= TDP_STORE_IDLE;
			store_count <= 8'h00;
			store_busy <= 1'b0;
		end else begin
			case (store_state)
				TDP_STORE_IDLE: begin
					if (store_go) begin
						store_state <= TDP_STORE_PROG;
						store_count <= `TDP_STORE_CYCLES;
						store_busy <= 1'b1;
					end
				end
				TDP_STORE_PROG: begin
					store_count <= store_count - 8'h01;
					if (store_count == 8'h01) begin
						store_state <= TDP_STORE_IDLE;
						store_busy <= 1'b0;
					end
				end
				default: begin
					store_state <= TDP_STORE_IDLE;
					store_busy <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			ref_gain <= TDP_GAIN_X1P5;
		end else begin
			ref_gain <= tdp_gain_t'(live.general[`TDP_GAIN_HI:`TDP_GAIN_LO]);
		end
	end

	// pin is low after start-up, so two-code starts low and power starts off
	always_ff @(posedge clock) begin
		if (!resetn) begin
			out_code <= '0;
		end else if (two_code_on) begin
			out_code <= pin.pin_level ? live.upper_code : live.lower_code;
		end else begin
			out_code <= live.main_code;
		end
	end

	// select tells the analog side which code is live, or that it is off
	always_ff @(posedge clock) begin
		if (!resetn) begin
			out_select <= TDP_OUT_MAIN;
		end else if (two_code_on) begin
			out_select <= pin.pin_level ? TDP_OUT_UPPER : TDP_OUT_LOWER;
		end else if (power_on) begin
			out_select <= pin.pin_level ? TDP_OUT_MAIN : TDP_OUT_OFF;
		end else begin
			out_select <= TDP_OUT_MAIN;
		end
	end

	// while the power function stays on, only the pin leaves power-down: the outside start pulse is needed
	always_ff @(posedge clock) begin
		if (!resetn) begin
			out_powered <= 1'b1;
			out_pulldown <= 1'b0;
		end else begin
			out_powered <= !power_on || pin.pin_level;
			out_pulldown <= power_on && !pin.pin_level;
		end
	end

	// edge taken from synchronised copies, so a slow pin gives one pulse only
	always_ff @(posedge clock) begin
		if (!resetn)
			trigger_pulse <= 1'b0;
		else
			trigger_pulse <= trigger_on && pin.pin_rise;
	end
endmodule

// ---- design/tdp_pin_if.sv ----
`timescale 1ns/1ps
interface tdp_pin_if;
	logic pin_level;
	logic pin_rise;
	modport sync_side (output pin_level, output pin_rise);
	modport user_side (input pin_level, input pin_rise);
endinterface

// ---- design/tdp_pin_sync.sv ----
`timescale 1ns/1ps
module tdp_pin_sync (
	input wire logic clock,
	input wire logic resetn,
	input wire logic general_input_pin,
	tdp_pin_if.sync_side pin
);
	import tdp_pkg::*;
	logic stage1;
	logic stage2;
	logic stage3;

	// first stage feeds only the second
	always_ff @(posedge clock) begin
		if (!resetn) begin
			stage1 <= 1'b0;
			stage2 <= 1'b0;
			stage3 <= 1'b0;
		end else begin
			stage1 <= general_input_pin;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	assign pin.pin_level = stage2;
	assign pin.pin_rise = stage2 & ~stage3;
endmodule

// ---- design/tdp_pkg.sv ----
package tdp_pkg;
	typedef enum logic [1:0] {
		TDP_OUT_MAIN,
		TDP_OUT_UPPER,
		TDP_OUT_LOWER,
		TDP_OUT_OFF
	} tdp_sel_t;
	typedef enum logic [1:0] {
		TDP_GAIN_X1P5,
		TDP_GAIN_X2,
		TDP_GAIN_X3,
		TDP_GAIN_X4
	} tdp_gain_t;
endpackage

// ---- verif/tdp_chk.sv ----
`timescale 1ns/1ps
module tdp_chk (
	input wire logic clock,
	input wire logic resetn,
	input wire logic general_input_pin,
	input wire logic [15:0] wr_data,
	input wire logic wr_command,
	input wire tdp_pkg::tdp_sel_t out_select,
	input wire logic out_powered,
	input wire logic out_pulldown,
	input wire logic trigger_pulse,
	input wire logic store_busy,
	input wire logic store_valid
);
	import tdp_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	AST_STORE_GO: assert property (
		$past(resetn) && wr_command && wr_data[4] && !store_busy |=> store_busy && store_valid)
		else $error("store not started");
	AST_STORE_LEN: assert property (
		$rose(store_busy) |-> ##15 store_busy ##1 !store_busy)
		else $error("store length");
	AST_PULSE_ONE: assert property (
		trigger_pulse |=> !trigger_pulse)
		else $error("trigger too long");
	AST_OFF_LOAD: assert property (
		out_select == TDP_OUT_OFF |-> !out_powered && out_pulldown)
		else $error("off state");
	AST_ON_NOLOAD: assert property (
		out_powered |-> !out_pulldown)
		else $error("load while on");
	AST_UPPER_PIN: assert property (
		out_select == TDP_OUT_UPPER |-> $past(general_input_pin, 3))
		else $error("upper early");
	AST_RESET_DEF: assert property (
		$rose(resetn) |-> out_select == TDP_OUT_MAIN && out_powered)
		else $error("reset state");
	// the programmed flag must also ride through a reset, so no disable here
	AST_VALID_KEEP: assert property (disable iff (1'b0)
		store_valid |=> store_valid)
		else $error("valid lost");
endmodule

// ---- verif/tdp_fb_model.sv ----
`timescale 1ns/1ps
module tdp_fb_model (
	input wire logic clock,
	input wire logic trip,
	input wire logic start_pulse,
	output logic general_input_pin
);
	// output load pulls the pin low at start-up
	initial general_input_pin = 1'b0;
	always @(negedge clock) general_input_pin <= trip | start_pulse;
endmodule

// ---- verif/threshold_dac_pin_control_tb.sv ----
`timescale 1ns/1ps
`include "tdp_consts.svh"
module threshold_dac_pin_control_tb;
	import tdp_pkg::*;
	logic clock, resetn, trip, pulse, general_input_pin;
	logic wr_setup2, wr_command, wr_general, wr_main, wr_upper, wr_lower;
	logic [5:0] st;
	logic [15:0] wr_data, d, u, l;
	logic [9:0] out_code;
	tdp_sel_t out_select;
	tdp_gain_t ref_gain;
	logic out_powered, out_pulldown, trigger_pulse, store_busy, store_valid;
	logic [31:0] seed;
	logic [3:0] cnt;
	int n_mismatch, comparisons, cycles, i;
	assign {wr_lower, wr_upper, wr_main, wr_general, wr_command, wr_setup2} = st;
	tdp_control dut (
		.clock(clock),
		.resetn(resetn),
		.general_input_pin(general_input_pin),
		.wr_data(wr_data),
		.wr_setup2(wr_setup2),
		.wr_command(wr_command),
		.wr_general(wr_general),
		.wr_main(wr_main),
		.wr_upper(wr_upper),
		.wr_lower(wr_lower),
		.out_code(out_code),
		.out_select(out_select),
		.out_powered(out_powered),
		.out_pulldown(out_pulldown),
		.ref_gain(ref_gain),
		.trigger_pulse(trigger_pulse),
		.store_busy(store_busy),
		.store_valid(store_valid)
	);
	tdp_fb_model fb (.clock(clock), .trip(trip), .start_pulse(pulse),
		.general_input_pin(general_input_pin));
	initial begin
		clock = 0;
		forever #2 clock = ~clock;
	end
	function logic [15:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction
	function logic [15:0] code_of(input logic [15:0] w);
		return {6'h00, w[11:2]};
	endfunction
	// host side: threshold over full scale times 1024, rounded to nearest, placed at 11:2
	function logic [15:0] thresh_word(input int mv, input int full_mv);
		return 16'(((mv * 1024 + full_mv / 2) / full_mv) << 2);
	endfunction
	task check(input string nm, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wr(input int r, input logic [15:0] w);
		@(negedge clock);
		st[r] = 1'b1;
		wr_data = w;
		@(negedge clock);
		st = 6'h00;
	endtask
	task tick(input int n);
		repeat (n) @(negedge clock);
	endtask
	task give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			n_mismatch++;
			give_verdict();
		end
	end
	initial begin
		{resetn, trip, pulse, st, wr_data} = 0;
		seed = 32'hd717cc51;
		tick(4);
		resetn = 1;
		check("select", TDP_OUT_MAIN, out_select);
		for (i = 0; i < 4; i++) begin
			wr(2, 16'(i));
			tick(3);
			check("gain", 16'(i), ref_gain);
		end
		d = rnd();
		wr(3, d);
		tick(3);
		check("main", code_of(d), out_code);
		$display("gain and main done");
		u = rnd();
		l = rnd();
		wr(4, u);
		wr(5, l);
		wr(0, 16'h1000);
		wr(1, 16'h0400);
		tick(4);
		check("code", code_of(l), out_code);
		for (i = 0; i < 8; i++) begin
			wr_data = rnd();
			trip <= wr_data[0];
			tick(5);
			check("code", code_of(wr_data[0] ? u : l), out_code);
		end
		// corner: 3 V and 1 V on a 5 V scale round to 614 and 205
		u = thresh_word(3000, 5000);
		l = thresh_word(1000, 5000);
		wr(4, u);
		wr(5, l);
		trip <= 1;
		tick(5);
		check("code", 16'd614, out_code);
		trip <= 0;
		tick(5);
		check("code", 16'd205, out_code);
		wr(1, 16'h0000);
		tick(4);
		check("select", TDP_OUT_MAIN, out_select);
		$display("two code done");
		wr(0, 16'h2000);
		wr(1, 16'h0400);
		tick(5);
		check("pulldown", 1, out_pulldown);
		pulse <= 1;
		tick(5);
		check("powered", 1, out_powered);
		check("code", code_of(d), out_code);
		pulse <= 0;
		tick(5);
		check("powered", 0, out_powered);
		wr(0, 16'h0800);
		tick(4);
		trip <= 1;
		cnt = 0;
		repeat (8) begin
			@(negedge clock);
			cnt += trigger_pulse;
		end
		check("trigger", 1, cnt);
		$display("power and trigger done");
		wr(0, 16'h1000);
		wr(1, 16'h0410);
		check("busy", 1, store_busy);
		check("valid", 1, store_valid);
		wr(1, 16'h0410);
		i = 0;
		while (store_busy !== 1'b0 && i < 40) begin
			tick(1);
			i++;
		end
		check("busy", 0, store_busy);
		// the repeat strobe fell in the busy time, so only the first count runs out
		check("wait", 16'(`TDP_STORE_CYCLES) - 16'd2, 16'(i));
		wr(0, 16'h0000);
		resetn = 0;
		tick(4);
		resetn = 1;
		tick(6);
		check("code", code_of(u), out_code);
		check("valid", 1, store_valid);
		$display("store done");
		give_verdict();
	end
endmodule
bind tdp_control tdp_chk chk (
	.clock(clock),
	.resetn(resetn),
	.general_input_pin(general_input_pin),
	.wr_data(wr_data),
	.wr_command(wr_command),
	.out_select(out_select),
	.out_powered(out_powered),
	.out_pulldown(out_pulldown),
	.trigger_pulse(trigger_pulse),
	.store_busy(store_busy),
	.store_valid(store_valid)
);
